// ### design/synth_reset_powerdown_ctrl.sv
// reset release, boot fetch start and deep power-down sequencing
`timescale 1ns/1ps
// Summary of operation
// - A rising edge of init_n puts the synthesis engine into its idle state.
// - Releasing init_n drives the running indicator low.
// - After release the processor fetches from ROM address 0100H with rom_select_n low.
// - While sleep_request_n is low every output and two-way pin is floated.
// - In sleep the oscillator and the clock multiplier are stopped.
// - The core clock is the 9.6 MHz crystal multiplied up to 38.4 MHz.
// - The running indicator goes high only once the synthesizer is fully operational.
module synth_reset_powerdown_ctrl #(
    parameter int unsigned LOCK_WAIT = rst_pkg::LOCK_CYCLES,
    parameter int unsigned INIT_WAIT = rst_pkg::INIT_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // board pins
    input wire logic init_n,
    input wire logic sleep_request_n,
    // clock generation
    input wire logic pll_locked,
    output logic osc_enable,
    output logic pll_enable,
    output logic [2:0] pll_mult,
    // core control
    output logic cpu_reset,
    output logic synth_idle,
    output logic [24:0] fetch_addr,
    output logic fetch_start,
    input wire logic synth_ready,
    // pins
    output logic rom_select_n,
    output logic rom_select_n_oe,
    output logic pins_oe,
    output logic run,
    output logic run_oe
);
    rst_pkg::pwr_state_t state;
    rst_pkg::pwr_state_t next_state;
    logic init_q;
    logic timer_start;
    logic [rst_pkg::CNT_W-1:0] timer_load;
    logic timer_done;
    logic init_rise;

    // init edge detect; pins are synchronous so no synchroniser
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_q <= 1'b0;
        end else begin
            init_q <= init_n;
        end
    end
    assign init_rise = init_n && !init_q;

    wait_timer #(.W(rst_pkg::CNT_W)) u_timer (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .start(timer_start),
        .load(timer_load),
        .done(timer_done)
    );

    always_comb begin
        next_state = state;
        timer_start = 1'b0;
        timer_load = '0;
        case (state)
            rst_pkg::ST_RESET: begin
                // board owns the 20 ms settle; we only re-check multiplier lock
                if (init_rise) begin
                    next_state = rst_pkg::ST_LOCK;
                    timer_start = 1'b1;
                    timer_load = rst_pkg::CNT_W'(LOCK_WAIT);
                end
            end
            rst_pkg::ST_LOCK: begin
                if (timer_done && pll_locked) begin
                    next_state = rst_pkg::ST_INIT;
                    timer_start = 1'b1;
                    timer_load = rst_pkg::CNT_W'(INIT_WAIT);
                end
            end
            rst_pkg::ST_INIT: begin
                if (timer_done && synth_ready) begin
                    next_state = rst_pkg::ST_RUN;
                end
            end
            rst_pkg::ST_RUN: begin
                next_state = rst_pkg::ST_RUN;
            end
            rst_pkg::ST_SLEEP: begin
                // only a fresh init pulse after wake ends sleep
                if (sleep_request_n && !init_n) begin
                    next_state = rst_pkg::ST_RESET;
                end
            end
            default: begin
                next_state = rst_pkg::ST_RESET;
            end
        endcase
        // sleep wins over everything, reset low wins over running
        if (!sleep_request_n) begin
            next_state = rst_pkg::ST_SLEEP;
        end else if (!init_n && state != rst_pkg::ST_SLEEP) begin
            next_state = rst_pkg::ST_RESET;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= rst_pkg::ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // clock generation control; sleep stops both so no internal clock runs
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_enable <= 1'b1;
        end else begin
            osc_enable <= next_state != rst_pkg::ST_SLEEP;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pll_enable <= 1'b1;
        end else begin
            pll_enable <= next_state != rst_pkg::ST_SLEEP;
        end
    end

    // fixed factor, registered only so the port leaves a flop
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pll_mult <= rst_pkg::PLL_MULT;
        end else begin
            pll_mult <= rst_pkg::PLL_MULT;
        end
    end

    // core reset and idle released only together with the running indicator
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_reset <= 1'b1;
        end else begin
            cpu_reset <= next_state != rst_pkg::ST_RUN;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            synth_idle <= 1'b1;
        end else begin
            synth_idle <= next_state != rst_pkg::ST_RUN;
        end
    end

    // boot address is constant; the processor latches it on the fetch pulse
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_addr <= '0;
        end else begin
            fetch_addr <= rst_pkg::BOOT_ADDR;
        end
    end

    // one pulse on the entry edge, never repeated while running
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_start <= 1'b0;
        end else begin
            fetch_start <= next_state == rst_pkg::ST_RUN && state != rst_pkg::ST_RUN;
        end
    end

    // pin drivers; rom select held low for the first fetch
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rom_select_n <= 1'b1;
        end else begin
            rom_select_n <= !(next_state == rst_pkg::ST_RUN);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rom_select_n_oe <= 1'b1;
        end else begin
            rom_select_n_oe <= next_state != rst_pkg::ST_SLEEP;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pins_oe <= 1'b1;
        end else begin
            pins_oe <= next_state != rst_pkg::ST_SLEEP;
        end
    end

    // run stays low outside running, so an external converter stays in reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            run <= 1'b0;
        end else begin
            run <= next_state == rst_pkg::ST_RUN;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_oe <= 1'b1;
        end else begin
            run_oe <= next_state != rst_pkg::ST_SLEEP;
        end
    end
endmodule : synth_reset_powerdown_ctrl

// ### design/rst_pkg.sv
// shared constants for the reset and power-down controller
package rst_pkg;
    localparam int unsigned REF_CLK_HZ = 200_000_000;
    localparam int unsigned XTAL_KHZ = 9600;
    localparam int unsigned CORE_KHZ = 38400;
    localparam logic [2:0] PLL_MULT = 3'(CORE_KHZ / XTAL_KHZ);
    localparam int unsigned SETTLE_MS = 20;
    localparam int unsigned SETTLE_CYCLES = SETTLE_MS * (REF_CLK_HZ / 1000);
    localparam int unsigned LOCK_US = 100;
    localparam int unsigned LOCK_CYCLES = LOCK_US * (REF_CLK_HZ / 1_000_000);
    localparam int unsigned INIT_US = 50;
    localparam int unsigned INIT_CYCLES = INIT_US * (REF_CLK_HZ / 1_000_000);
    localparam logic [24:0] BOOT_ADDR = 25'h0000100;
    localparam int unsigned CNT_W = 24;
    typedef enum logic [4:0] {
        ST_RESET = 5'b00001,
        ST_LOCK  = 5'b00010,
        ST_INIT  = 5'b00100,
        ST_RUN   = 5'b01000,
        ST_SLEEP = 5'b10000
    } pwr_state_t;
endpackage : rst_pkg

// ### design/wait_timer.sv
// down counter that reports when a programmed wait has elapsed
`timescale 1ns/1ps
module wait_timer #(
    parameter int unsigned W = 24
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // control
    input wire logic start,
    input wire logic [W-1:0] load,
    // status
    output logic done
);
    logic [W-1:0] count;
    logic busy;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
            busy <= 1'b0;
        end else if (start) begin
            count <= load;
            busy <= 1'b1;
        end else if (busy && count != '0) begin
            count <= count - 1'b1;
        end else begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= 1'b0;
        end else if (start) begin
            done <= 1'b0;
        end else if (busy && count == '0) begin
            // stands until the next start, so a late lock or ready still counts
            done <= 1'b1;
        end
    end
endmodule : wait_timer

// ### verif/synth_reset_powerdown_ctrl_asserts.sv
// port assertions for the reset and power-down controller
`timescale 1ns/1ps
module synth_reset_powerdown_ctrl_asserts (
    // clock, reset, board pins, core ready
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic init_n,
    input wire logic sleep_request_n,
    input wire logic synth_ready,
    // outputs watched
    input wire logic osc_enable,
    input wire logic pll_enable,
    input wire logic cpu_reset,
    input wire logic synth_idle,
    input wire logic [24:0] fetch_addr,
    input wire logic fetch_start,
    input wire logic rom_select_n,
    input wire logic rom_select_n_oe,
    input wire logic pins_oe,
    input wire logic run,
    input wire logic run_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sleep_float_a: assert property (!sleep_request_n |=> !pins_oe && !run_oe)
        else $error("pins driven while asleep");
    clock_stop_a: assert property (!sleep_request_n |=> !osc_enable && !pll_enable)
        else $error("clocks running while asleep");
    run_ready_a: assert property ($rose(run) |-> $past(synth_ready))
        else $error("run raised before core ready");
    run_state_a: assert property (run |-> !synth_idle && !rom_select_n)
        else $error("run high outside running state");
    init_hold_a: assert property (!init_n && sleep_request_n |=> synth_idle && !run)
        else $error("core not held while init low");
    release_idle_a: assert property ($rose(init_n) && sleep_request_n |=> !run && synth_idle)
        else $error("release did not idle the core");
    boot_fetch_a: assert property (fetch_start |-> fetch_addr == 25'h0000100 && !rom_select_n)
        else $error("boot fetch address or select wrong");
    fetch_pulse_a: assert property (fetch_start |=> !fetch_start)
        else $error("fetch start longer than one cycle");
    sleep_select_a: assert property (!sleep_request_n |=> !rom_select_n_oe)
        else $error("rom select driven while asleep");
    init_reset_a: assert property (!init_n && sleep_request_n |=>
        cpu_reset && rom_select_n && !fetch_start)
        else $error("memory access while init low");
endmodule : synth_reset_powerdown_ctrl_asserts
bind synth_reset_powerdown_ctrl synth_reset_powerdown_ctrl_asserts chk_u (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .init_n(init_n),
    .sleep_request_n(sleep_request_n),
    .synth_ready(synth_ready),
    .osc_enable(osc_enable),
    .pll_enable(pll_enable),
    .cpu_reset(cpu_reset),
    .synth_idle(synth_idle),
    .fetch_addr(fetch_addr),
    .fetch_start(fetch_start),
    .rom_select_n(rom_select_n),
    .rom_select_n_oe(rom_select_n_oe),
    .pins_oe(pins_oe),
    .run(run),
    .run_oe(run_oe)
);

// ### verif/board_model.sv
// board reset network and sleep control
`timescale 1ns/1ps
module board_model (
    // clock and pins
    input wire logic ref_clk,
    output logic init_n,
    output logic sleep_request_n
);
    initial {init_n, sleep_request_n} = 2'b01;
    task automatic pulse_init(input int hold);
        @(negedge ref_clk) init_n <= 1'b0;
        repeat (hold) @(negedge ref_clk);
        init_n <= 1'b1;
    endtask : pulse_init
    task automatic go_sleep();
        @(negedge ref_clk) sleep_request_n <= 1'b0;
    endtask : go_sleep
    // sleep released before init, else the part stays asleep
    task automatic wake();
        @(negedge ref_clk) sleep_request_n <= 1'b1;
        pulse_init(4);
    endtask : wake
endmodule : board_model

// ### verif/test_synth_reset_powerdown_ctrl.sv
// self-checking bench for the reset and power-down controller
`timescale 1ns/1ps
module test_synth_reset_powerdown_ctrl;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic pll_locked = 1'b0;
    logic synth_ready = 1'b0;
    logic init_n, sleep_request_n, osc_enable, pll_enable, cpu_reset, synth_idle, fetch_start;
    logic rom_select_n, rom_select_n_oe, pins_oe, run, run_oe;
    logic [2:0] pll_mult;
    logic [24:0] fetch_addr;
    logic [15:0] seed = 16'h3470;
    int err_count = 0;
    int checked = 0;
    always #2.5 ref_clk = ~ref_clk;
    board_model board_u (
        .ref_clk(ref_clk),
        .init_n(init_n),
        .sleep_request_n(sleep_request_n)
    );
    synth_reset_powerdown_ctrl #(.LOCK_WAIT(4), .INIT_WAIT(4)) dut_u (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .init_n(init_n),
        .sleep_request_n(sleep_request_n),
        .pll_locked(pll_locked),
        .osc_enable(osc_enable),
        .pll_enable(pll_enable),
        .pll_mult(pll_mult),
        .cpu_reset(cpu_reset),
        .synth_idle(synth_idle),
        .fetch_addr(fetch_addr),
        .fetch_start(fetch_start),
        .synth_ready(synth_ready),
        .rom_select_n(rom_select_n),
        .rom_select_n_oe(rom_select_n_oe),
        .pins_oe(pins_oe),
        .run(run),
        .run_oe(run_oe)
    );
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic end_sim();
        if (err_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // lock and ready arrive at random, both prompt and slow
    task automatic wait_run();
        for (int i = 0; i < 400; i++) begin
            @(negedge ref_clk);
            if (run === 1'b1) begin
                chk(fetch_addr, 25'h0000100);
                chk({fetch_start, rom_select_n, cpu_reset}, 3'b100);
                return;
            end
            seed = lfsr(seed);
            {pll_locked, synth_ready} = seed[1:0];
        end
        err_count++;
        end_sim();
    endtask : wait_run
    initial begin
        repeat (20) @(negedge ref_clk);
        arst_n = 1'b1;
        for (int n = 0; n < 4; n++) begin
            seed = lfsr(seed);
            board_u.pulse_init(n == 0 ? 40 : 1 + seed[2:0]);
            if (n == 2) board_u.pulse_init(1); // abort inside the lock wait
            @(negedge ref_clk);
            chk({run, synth_idle, cpu_reset}, 3'b011);
            wait_run();
        end
        board_u.go_sleep();
        @(negedge ref_clk);
        chk({pins_oe, rom_select_n_oe, run_oe, osc_enable, pll_enable}, 5'h00);
        // init while still asleep must not wake the part
        board_u.pulse_init(2);
        @(negedge ref_clk);
        chk({pins_oe, osc_enable, run, cpu_reset}, 4'h1);
        board_u.wake();
        @(negedge ref_clk);
        chk({osc_enable, pll_enable, pll_mult, pins_oe, rom_select_n_oe, run_oe}, 8'he7);
        wait_run();
        end_sim();
    end
endmodule : test_synth_reset_powerdown_ctrl
